/* File: tric_pkg.sv */
// Constants shared by the tape reader input control
package tric_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FN_LOCK_MS = 70;
  localparam int unsigned READY_MS = 500;
  localparam int unsigned ACK_STRETCH_MS = 2;
  localparam int unsigned PULSE_US = 2;
  localparam int unsigned PULSE_CYC = (PULSE_US * CLK_HZ) / 1_000_000;
  localparam int unsigned FN_LOCK_CYC = FN_LOCK_MS * (CLK_HZ / 1000);
  localparam int unsigned READY_CYC = READY_MS * (CLK_HZ / 1000);
  localparam int unsigned ACK_STRETCH_CYC = ACK_STRETCH_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 25;
  localparam int PCNT_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'H00;
  localparam logic [7:0] ADDR_STATUS = 8'H04;
  localparam logic [7:0] ADDR_DATA = 8'H08;
  localparam int CTRL_SOFT_CLEAR = 0;
  localparam int CTRL_REQ_WANT = 1;
  localparam int CTRL_SER_TAKE = 2;
  localparam int FW_INPUT_SEL = 3;
  localparam int FW_KB_EN = 4;
  localparam int FW_READ_EN = 5;
  localparam int FW_START_EN = 6;
  localparam int SYNC_N = 6;
  localparam int SY_SPROCKET = 0;
  localparam int SY_HEAD = 1;
  localparam int SY_KB_CLEAR = 2;
  localparam int SY_GO_CANCEL = 3;
  localparam int SY_MODE_CANCEL = 4;
  localparam int SY_MASTER = 5;
  typedef enum logic [2:0] {RD_IDLE, RD_WAIT, RD_ADVANCE, RD_HOLD, RD_ACK} tric_rd_state_t;
endpackage : tric_pkg

/* File: tric_top.sv */
// Tape reader input control with APB register access
//
// Summary of operation
// - Keyboard clear drops keyboard and read modes and clears keyboard flags.
// - Master clear blocks function requests for 70 ms, then allows them.
// - Master clear also acts as a keyboard clear.
// - Master clear sets serializer ready, which permits function requests.
// - Function acknowledge rising edge decodes the word; its 2 us pulse shows only in status.
// - Word bit 3 selects input, bit 5 enables read, bit 6 start-read.
// - Read command selects read mode, lamps, and sets start-read flag.
// - Read mode inhibits keyboard mode and clears keyboard flags.
// - Reader motor runs while read mode is selected.
// - Reader ready sets 0.5 s after read entry, clear outside read mode.
// - Reader works only with the tape head lowered.
// - With reader ready and no frame awaiting acknowledge, tape advance stays on.
// - Sprocket stops advance and loads the frame into the holding register.
// - A loaded frame raises the input word request.
// - Acknowledge drops request, advances tape, clears holding 2 us later.
// - A frame and its request are held until acknowledged, no timeout.
// - While advancing without keyboard ready or acknowledge, holding stays clear.
// - Head raised, cancel buttons or master clear stop reading.
// - Acknowledge stretched to 2 ms holds reader request enable clear.
// - No function request for 70 ms after any function acknowledge.
`timescale 1ns/1ps
`default_nettype none
module tric_top
  import tric_pkg::*;
#(
  parameter int unsigned FN_LOCK_CYCLES = FN_LOCK_CYC,
  parameter int unsigned READY_CYCLES = READY_CYC,
  parameter int unsigned ACK_STRETCH_CYCLES = ACK_STRETCH_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] function_word,
  input wire logic function_word_ack,
  output logic function_word_request,
  output logic input_word_request,
  input wire logic input_word_ack,
  output logic [7:0] input_data,
  input wire logic [7:0] tape_data,
  input wire logic sprocket,
  input wire logic head_lowered,
  output logic motor_start,
  output logic tape_advance,
  input wire logic keyboard_clear_button,
  input wire logic reader_go_cancel_button,
  input wire logic reader_mode_cancel_button,
  input wire logic master_clear_button,
  input wire logic keyboard_char_strobe,
  output logic read_lamp,
  output logic start_read_lamp,
  output logic keyboard_lamp
);
  import tric_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_N-1:0] sync_raw;
  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;
  logic sprocket_d_reg;
  assign sync_raw = {master_clear_button, reader_mode_cancel_button, reader_go_cancel_button,
                     keyboard_clear_button, head_lowered, sprocket};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= sync_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      sprocket_d_reg <= 1'b0;
    else
      sprocket_d_reg <= sync2_reg[SY_SPROCKET];
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic soft_clear_reg;
  logic req_want_reg;
  logic ser_take;
  logic apb_wr;
  logic addr_ok;
  logic [31:0] status_word;
  assign apb_wr = psel && penable && pready && pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_DATA);
  assign ser_take = apb_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_SER_TAKE];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'H0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          ADDR_CTRL: prdata <= {30'H0000_0000, req_want_reg, 1'b0};
          ADDR_STATUS: prdata <= status_word;
          ADDR_DATA: prdata <= {24'H00_0000, input_data};
          default: prdata <= 32'H0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      soft_clear_reg <= 1'b0;
      req_want_reg <= 1'b0;
    end
    else
    begin
      soft_clear_reg <= apb_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_SOFT_CLEAR];
      if (apb_wr && (paddr == ADDR_CTRL))
        req_want_reg <= pwdata[CTRL_REQ_WANT];
    end
  end

  // ****************************************
  // Master clear and function word handling
  // ****************************************
  logic mc;
  logic kb_clear;
  logic fn_ack_d_reg;
  logic decode_go;
  logic [PCNT_W-1:0] fn_pulse_cnt_reg;
  logic [CNT_W-1:0] lock_cnt_reg;
  logic ser_ready_reg;
  assign mc = sync2_reg[SY_MASTER] || soft_clear_reg;
  assign kb_clear = sync2_reg[SY_KB_CLEAR] || mc;
  assign decode_go = function_word_ack && !fn_ack_d_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fn_ack_d_reg <= 1'b0;
      fn_pulse_cnt_reg <= '0;
    end
    else
    begin
      fn_ack_d_reg <= function_word_ack;
      if (decode_go)
        fn_pulse_cnt_reg <= PCNT_W'(PULSE_CYC);
      else if (fn_pulse_cnt_reg != '0)
        fn_pulse_cnt_reg <= fn_pulse_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      lock_cnt_reg <= '0;
    else if (mc || decode_go)
      lock_cnt_reg <= CNT_W'(FN_LOCK_CYCLES);
    else if (lock_cnt_reg != '0)
      lock_cnt_reg <= lock_cnt_reg - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      ser_ready_reg <= 1'b1;
    else if (mc)
      ser_ready_reg <= 1'b1;
    else if (ser_take)
      ser_ready_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      function_word_request <= 1'b0;
    else
      function_word_request <= req_want_reg && ser_ready_reg && (lock_cnt_reg == '0);
  end

  // ****************************************
  // Mode selection
  // ****************************************
  logic read_mode_reg;
  logic start_read_reg;
  logic kb_mode_reg;
  logic fw_sel;
  logic fw_stop;
  assign fw_sel = decode_go && function_word[FW_INPUT_SEL];
  assign fw_stop = fw_sel && !function_word[FW_KB_EN] && !function_word[FW_READ_EN]
                   && !function_word[FW_START_EN];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      read_mode_reg <= 1'b0;
      start_read_reg <= 1'b0;
      kb_mode_reg <= 1'b0;
    end
    else
    begin
      if (kb_clear || fw_stop || sync2_reg[SY_MODE_CANCEL])
      begin
        read_mode_reg <= 1'b0;
        start_read_reg <= 1'b0;
      end
      else
      begin
        if (fw_sel && function_word[FW_READ_EN])
          read_mode_reg <= 1'b1;
        if (sync2_reg[SY_GO_CANCEL])
          start_read_reg <= 1'b0;
        else if (fw_sel && function_word[FW_START_EN])
          start_read_reg <= 1'b1;
      end
      if (kb_clear || fw_stop || read_mode_reg)
        kb_mode_reg <= 1'b0;
      else if (fw_sel && function_word[FW_KB_EN] && !function_word[FW_READ_EN])
        kb_mode_reg <= 1'b1;
    end
  end

  // ****************************************
  // Keyboard flags
  // ****************************************
  logic kb_input_ready_reg;
  logic interrupt_reg;
  logic kb_req_en_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kb_input_ready_reg <= 1'b0;
      interrupt_reg <= 1'b0;
      kb_req_en_reg <= 1'b0;
    end
    else if (keyboard_char_strobe && kb_mode_reg)
    begin
      kb_input_ready_reg <= 1'b1;
      interrupt_reg <= 1'b1;
      kb_req_en_reg <= 1'b1;
    end
    else if (read_mode_reg || kb_clear || !kb_mode_reg)
    begin
      kb_input_ready_reg <= 1'b0;
      interrupt_reg <= 1'b0;
      kb_req_en_reg <= 1'b0;
    end
  end

  // ****************************************
  // Reader sequencing
  // ****************************************
  tric_rd_state_t rd_state_reg;
  logic [CNT_W-1:0] ready_cnt_reg;
  logic reader_ready_reg;
  logic [CNT_W-1:0] stretch_cnt_reg;
  logic reader_req_en_reg;
  logic [PCNT_W-1:0] ack_cnt_reg;
  logic rd_run;
  logic sprocket_rise;
  assign rd_run = read_mode_reg && start_read_reg && sync2_reg[SY_HEAD] && !mc;
  assign sprocket_rise = sync2_reg[SY_SPROCKET] && !sprocket_d_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ready_cnt_reg <= '0;
      reader_ready_reg <= 1'b0;
    end
    else if (!read_mode_reg)
    begin
      ready_cnt_reg <= CNT_W'(READY_CYCLES);
      reader_ready_reg <= 1'b0;
    end
    else if (ready_cnt_reg != '0)
      ready_cnt_reg <= ready_cnt_reg - 1'b1;
    else
      reader_ready_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stretch_cnt_reg <= '0;
      reader_req_en_reg <= 1'b0;
    end
    else if (rd_state_reg == RD_HOLD && input_word_ack)
    begin
      stretch_cnt_reg <= CNT_W'(ACK_STRETCH_CYCLES);
      reader_req_en_reg <= 1'b0;
    end
    else if (stretch_cnt_reg != '0)
    begin
      stretch_cnt_reg <= stretch_cnt_reg - 1'b1;
      reader_req_en_reg <= 1'b0;
    end
    else
      reader_req_en_reg <= reader_ready_reg && !sync2_reg[SY_SPROCKET];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_state_reg <= RD_IDLE;
      ack_cnt_reg <= '0;
    end
    else if (!rd_run)
      rd_state_reg <= RD_IDLE;
    else
    begin
      case (rd_state_reg)
        RD_IDLE: rd_state_reg <= RD_WAIT;
        RD_WAIT:
          if (reader_ready_reg)
            rd_state_reg <= RD_ADVANCE;
        RD_ADVANCE:
          if (sprocket_rise && reader_req_en_reg)
            rd_state_reg <= RD_HOLD;
        RD_HOLD:
          if (input_word_ack)
          begin
            rd_state_reg <= RD_ACK;
            ack_cnt_reg <= PCNT_W'(PULSE_CYC - 1);
          end
        RD_ACK:
          if (ack_cnt_reg == '0)
            rd_state_reg <= RD_ADVANCE;
          else
            ack_cnt_reg <= ack_cnt_reg - 1'b1;
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      input_data <= 8'H00;
    else if (rd_run && rd_state_reg == RD_ADVANCE && sprocket_rise && reader_req_en_reg)
      input_data <= tape_data;
    else if (rd_run && rd_state_reg == RD_ACK && ack_cnt_reg == '0)
      input_data <= 8'H00;
    else if (rd_run && rd_state_reg == RD_ADVANCE && !kb_input_ready_reg && !input_word_ack)
      input_data <= 8'H00;
  end

  // ****************************************
  // Outputs toward reader, channel and lamps
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      motor_start <= 1'b0;
      tape_advance <= 1'b0;
      input_word_request <= 1'b0;
      read_lamp <= 1'b0;
      start_read_lamp <= 1'b0;
      keyboard_lamp <= 1'b0;
    end
    else
    begin
      motor_start <= read_mode_reg;
      input_word_request <= rd_run && (rd_state_reg == RD_HOLD) && !input_word_ack;
      tape_advance <= rd_run && reader_ready_reg && (rd_state_reg == RD_ADVANCE
                      && !(sprocket_rise && reader_req_en_reg)
                      || rd_state_reg == RD_HOLD && input_word_ack
                      || rd_state_reg == RD_ACK);
      read_lamp <= read_mode_reg;
      start_read_lamp <= start_read_reg;
      keyboard_lamp <= kb_mode_reg;
    end
  end

  assign status_word = {20'H0_0000, fn_pulse_cnt_reg != '0, kb_req_en_reg, interrupt_reg,
                        kb_input_ready_reg, reader_req_en_reg, input_word_request,
                        lock_cnt_reg != '0, ser_ready_reg, kb_mode_reg, reader_ready_reg,
                        start_read_reg, read_mode_reg};

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_read_cmd;
    fw_sel && function_word[FW_READ_EN] && function_word[FW_START_EN] && !kb_clear
      && !sync2_reg[SY_MODE_CANCEL] && !sync2_reg[SY_GO_CANCEL];
  endsequence
  sequence s_taken;
    rd_run && rd_state_reg == RD_HOLD && input_word_ack;
  endsequence

  property p_lock_blocks;
    @(posedge clk_sys) disable iff (!reset_n) lock_cnt_reg != '0 |=> !function_word_request;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("request during lockout");
  property p_mc_lock;
    @(posedge clk_sys) disable iff (!reset_n) mc |=> lock_cnt_reg == CNT_W'(FN_LOCK_CYCLES);
  endproperty
  a_mc_lock: assert property (p_mc_lock) else $error("master clear lockout not loaded");
  property p_mc_ser;
    @(posedge clk_sys) disable iff (!reset_n) mc |=> ser_ready_reg;
  endproperty
  a_mc_ser: assert property (p_mc_ser) else $error("serializer ready not set");
  property p_kb_clear;
    @(posedge clk_sys) disable iff (!reset_n) kb_clear |=> !read_mode_reg && !kb_mode_reg;
  endproperty
  a_kb_clear: assert property (p_kb_clear) else $error("modes not dropped on clear");
  property p_read_cmd;
    @(posedge clk_sys) disable iff (!reset_n)
      s_read_cmd |=> read_mode_reg && start_read_reg ##1 read_lamp && start_read_lamp;
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read command not applied");
  property p_motor;
    @(posedge clk_sys) disable iff (!reset_n) read_mode_reg ##1 read_mode_reg |-> motor_start;
  endproperty
  a_motor: assert property (p_motor) else $error("motor off in read mode");
  property p_ready_clear;
    @(posedge clk_sys) disable iff (!reset_n) !read_mode_reg |=> !reader_ready_reg;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("reader ready outside read");
  property p_load;
    @(posedge clk_sys) disable iff (!reset_n)
      rd_run && rd_state_reg == RD_ADVANCE && sprocket_rise && reader_req_en_reg
      |=> !tape_advance && input_data == $past(tape_data) ##1 input_word_request;
  endproperty
  a_load: assert property (p_load) else $error("frame not loaded");
  property p_ack;
    @(posedge clk_sys) disable iff (!reset_n)
      s_taken |=> !input_word_request && !reader_req_en_reg ##[1:90] input_data == 8'H00;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge sequence wrong");
  property p_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      rd_run && rd_state_reg == RD_HOLD && !input_word_ack |=> rd_state_reg == RD_HOLD || !rd_run;
  endproperty
  a_hold: assert property (p_hold) else $error("frame dropped before acknowledge");
endmodule : tric_top
`default_nettype wire

/* File: tric_host_model.sv */
// Behavioural model of the computer I/O channel facing the reader control
`timescale 1ns/1ps
`default_nettype none
module tric_host_model
  import tric_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic input_word_request,
  input wire logic [7:0] input_data,
  input wire logic [7:0] ack_wait,
  output logic [7:0] function_word,
  output logic function_word_ack,
  output logic input_word_ack,
  output logic [7:0] last_frame
);
  int n;

  initial
  begin
    function_word = 8'H00;
    function_word_ack = 1'b0;
    input_word_ack = 1'b0;
    last_frame = 8'H00;
  end

  // ************************************************************
  // Function word with acknowledge
  // ************************************************************
  task automatic send_word(input logic [7:0] w);
    @(posedge clk_sys);
    function_word <= w;
    function_word_ack <= 1'b1;
    repeat (4) @(posedge clk_sys);
    function_word_ack <= 1'b0;
    // Released lines show no stale word
    function_word <= ~w;
    @(posedge clk_sys);
  endtask : send_word

  // ************************************************************
  // Input word: after ack_wait cycles, store and acknowledge in the same cycle
  // ************************************************************
  always
  begin
    @(posedge clk_sys);
    if (reset_n && input_word_request)
    begin
      repeat (ack_wait) @(posedge clk_sys);
      last_frame <= input_data;
      input_word_ack <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (input_word_request && n < 50)
      begin
        @(posedge clk_sys);
        n++;
      end
      input_word_ack <= 1'b0;
      @(posedge clk_sys);
    end
  end
endmodule : tric_host_model
`default_nettype wire

/* File: tape_reader_input_control_test.sv */
// Self-checking testbench for the tape reader input control
`timescale 1ns/1ps
`default_nettype none
module tape_reader_input_control_test;
  import tric_pkg::*;
  localparam int unsigned LOCK = 50;
  localparam int unsigned RDY = 100;
  localparam int unsigned STR = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'H00;
  logic [31:0] pwdata = 32'H0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr;
  logic [7:0] function_word, input_data, last_frame;
  logic function_word_ack, function_word_request, input_word_request, input_word_ack;
  logic [7:0] tape_data = 8'H00;
  logic [7:0] ack_wait = 8'H00;
  logic sprocket = 1'b0;
  logic head_lowered = 1'b0;
  logic [3:0] btn = 4'H0;
  logic kb_strobe = 1'b0;
  logic motor_start, tape_advance, read_lamp, start_read_lamp, keyboard_lamp;
  int failures = 0;
  int samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  tric_top #(.FN_LOCK_CYCLES(LOCK), .READY_CYCLES(RDY), .ACK_STRETCH_CYCLES(STR)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .function_word(function_word), .function_word_ack(function_word_ack),
    .function_word_request(function_word_request), .input_word_request(input_word_request),
    .input_word_ack(input_word_ack), .input_data(input_data), .tape_data(tape_data),
    .sprocket(sprocket), .head_lowered(head_lowered), .motor_start(motor_start),
    .tape_advance(tape_advance), .keyboard_clear_button(btn[0]),
    .reader_go_cancel_button(btn[1]), .reader_mode_cancel_button(btn[2]),
    .master_clear_button(btn[3]), .keyboard_char_strobe(kb_strobe),
    .read_lamp(read_lamp), .start_read_lamp(start_read_lamp), .keyboard_lamp(keyboard_lamp));

  tric_host_model u_host (
    .clk_sys(clk_sys), .reset_n(reset_n), .input_word_request(input_word_request),
    .input_data(input_data), .ack_wait(ack_wait), .function_word(function_word),
    .function_word_ack(function_word_ack), .input_word_ack(input_word_ack),
    .last_frame(last_frame));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20)
      failures++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic status(input logic [31:0] mask, input logic [31:0] exp, input string s);
    apb(1'b0, ADDR_STATUS, 32'H0);
    check(s, rdata & mask, exp);
  endtask : status

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic frame(input logic [7:0] d);
    @(posedge clk_sys);
    tape_data <= d;
    sprocket <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sprocket <= 1'b0;
    tape_data <= ~d;
  endtask : frame

  task automatic done(input string s);
    $display("Test %s finished, failures so far %0d", s, failures);
  endtask : done

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    results();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle(1);
    check("motor", motor_start, 1'b0);
    check("advance", tape_advance, 1'b0);
    status(32'H10, 32'H10, "ser_ready");
    apb(1'b0, 8'H0C, 32'H0);
    check("unmapped_err", rerr, 1'b1);
    check("unmapped_data", rdata, 32'H0);
    done("reset");
    apb(1'b1, ADDR_CTRL, 32'H1);
    apb(1'b1, ADDR_CTRL, 32'H2);
    settle(5);
    check("fn_req_locked", function_word_request, 1'b0);
    settle(LOCK);
    check("fn_req_free", function_word_request, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'H6);
    status(32'H10, 32'H00, "ser_taken");
    settle(1);
    check("fn_req_no_ser", function_word_request, 1'b0);
    done("lockout");
    u_host.send_word(8'H68);
    settle(2);
    check("fn_req_after_ack", function_word_request, 1'b0);
    check("motor_read", motor_start, 1'b1);
    check("read_lamp", read_lamp, 1'b1);
    check("start_lamp", start_read_lamp, 1'b1);
    status(32'H7, 32'H3, "read_not_ready");
    settle(RDY + 20);
    check("advance_head_up", tape_advance, 1'b0);
    @(posedge clk_sys);
    head_lowered <= 1'b1;
    settle(10);
    check("advance_on", tape_advance, 1'b1);
    done("read_start");
    ack_wait <= 8'HC8;
    frame(8'HA5);
    settle(3);
    check("req_up", input_word_request, 1'b1);
    check("advance_stop", tape_advance, 1'b0);
    check("frame", input_data, 8'HA5);
    settle(150);
    check("req_held", input_word_request, 1'b1);
    apb(1'b0, ADDR_DATA, 32'H0);
    check("data_reg", rdata, 32'HA5);
    while (input_word_request === 1'b1)
      @(posedge clk_sys);
    settle(2);
    check("req_dropped", input_word_request, 1'b0);
    check("advance_again", tape_advance, 1'b1);
    check("host_frame", last_frame, 8'HA5);
    settle(100);
    check("holding_clear", input_data, 8'H00);
    frame(8'H3C);
    settle(3);
    check("stretch_ignore", input_word_request, 1'b0);
    check("stretch_advance", tape_advance, 1'b1);
    settle(STR);
    ack_wait <= 8'H00;
    frame(8'H5A);
    settle(30);
    check("host_frame2", last_frame, 8'H5A);
    check("advance_resume", tape_advance, 1'b1);
    settle(100);
    check("holding_clear2", input_data, 8'H00);
    done("frames");
    u_host.send_word(8'H08);
    settle(5);
    check("stop_motor", motor_start, 1'b0);
    check("stop_advance", tape_advance, 1'b0);
    status(32'H3, 32'H0, "stop_mode");
    done("stop_word");
    u_host.send_word(8'H18);
    settle(3);
    check("kb_lamp", keyboard_lamp, 1'b1);
    @(posedge clk_sys);
    kb_strobe <= 1'b1;
    @(posedge clk_sys);
    kb_strobe <= 1'b0;
    status(32'H108, 32'H108, "kb_ready");
    u_host.send_word(8'H68);
    settle(3);
    status(32'H709, 32'H001, "kb_flags_clear");
    done("keyboard");
    for (int i = 0; i < 5; i++)
    begin
      u_host.send_word(8'H68);
      settle(RDY + 20);
      check("advance_before", tape_advance, 1'b1);
      @(posedge clk_sys);
      if (i < 4)
        btn[i] <= 1'b1;
      else
        head_lowered <= 1'b0;
      repeat (5) @(posedge clk_sys);
      btn <= 4'H0;
      settle(10);
      check("advance_halt", tape_advance, 1'b0);
      if (i != 1 && i != 4)
        status(32'H3, 32'H0, "mode_off");
      else if (i == 1)
        status(32'H2, 32'H0, "start_off");
      if (i == 3)
        check("mc_lock", function_word_request, 1'b0);
      @(posedge clk_sys);
      head_lowered <= 1'b1;
    end
    done("stops");
    results();
  end
endmodule : tape_reader_input_control_test
`default_nettype wire
